// ==== ast_transmitter.sv ====
// asynchronous serial transmitter with AXI4-Lite register access
// assumes clock_in is the oscillator; sleep_in comes from same domain
`timescale 1ns/1ps
`include "ast_defines.svh"

module ast_transmitter
  import ast_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,

  // chip power state
  input  wire logic       sleep_in,

  // AXI4-Lite write address
  input  wire logic       s_axi_awvalid_in,
  output logic            s_axi_awready_out,
  input  wire logic [7:0] s_axi_awaddr_in,

  // AXI4-Lite write data
  input  wire logic       s_axi_wvalid_in,
  output logic            s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0] s_axi_wstrb_in,

  // AXI4-Lite write response
  output logic            s_axi_bvalid_out,
  input  wire logic       s_axi_bready_in,
  output logic [1:0]      s_axi_bresp_out,

  // AXI4-Lite read address
  input  wire logic       s_axi_arvalid_in,
  output logic            s_axi_arready_out,
  input  wire logic [7:0] s_axi_araddr_in,

  // AXI4-Lite read data
  output logic            s_axi_rvalid_out,
  input  wire logic       s_axi_rready_in,
  output logic [31:0]     s_axi_rdata_out,
  output logic [1:0]      s_axi_rresp_out,

  // serial line and request
  output logic            tx_out,
  output logic            transmit_request_out
);

  ast_regs_t s;
  ast_regs_t n;

  logic       active;
  logic       bit_tick;
  logic       do_write;
  logic       wr_buf;
  logic       transmit_enable_rise;
  logic       load;
  logic       restart;
  logic       shift_register_empty;
  logic [3:0] last_bit;
  logic [7:0] rd_byte;
  logic       rd_hit;

  // port runs only with port enable, transmit enable, clocked mode off
  assign active = s.rx_ctrl[`AST_SERIAL_PORT_ENABLE_BIT]
                  && s.tx_ctrl[`AST_TRANSMIT_ENABLE_BIT]
                  && !s.tx_ctrl[`AST_SYNC_BIT];

  assign shift_register_empty = (s.state == AST_IDLE);

  assign last_bit = s.tx_ctrl[`AST_TX9_BIT] ? `AST_LAST_BIT_9
                                            : `AST_LAST_BIT_8;

  assign do_write = s.aw_full && s.w_full && !s.bvalid;

  // bus handshakes
  assign s_axi_awready_out = !s.aw_full;
  assign s_axi_wready_out  = !s.w_full;
  assign s_axi_bvalid_out  = s.bvalid;
  assign s_axi_bresp_out   = s.bresp;
  assign s_axi_arready_out = !s.rvalid;
  assign s_axi_rvalid_out  = s.rvalid;
  assign s_axi_rdata_out   = {24'h000000, s.rdata};
  assign s_axi_rresp_out   = s.rresp;

  assign tx_out = s.tx_line;

  // enable only gates the request; the flag itself is unconditional
  assign transmit_request_out = s.flags[`AST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT]
                                && s.enables[`AST_TRANSMIT_INTERRUPT_ENABLE_BIT];

  ast_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .enable_in     (active),
    .hold_in       (sleep_in),
    .restart_in    (restart),
    .high_speed_in (s.tx_ctrl[`AST_HIGH_SPEED_BAUD_SELECT_BIT]),
    .divisor_in    (s.divisor),
    .bit_tick_out  (bit_tick)
  );

  // read decode; the shift register has no address
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr_in)
      `AST_OFS_FLAGS:
        rd_byte = s.flags;
      `AST_OFS_ENABLES:
        rd_byte = s.enables;
      `AST_OFS_PRIO:
        rd_byte = s.priorities;
      `AST_OFS_RXSTA:
        rd_byte = s.rx_ctrl;
      `AST_OFS_TXBUF:
        rd_byte = s.tx_buf;
      `AST_OFS_TRANSMIT_STATUS_CONTROL:
      begin
        rd_byte = s.tx_ctrl;
        rd_byte[`AST_SHIFT_REGISTER_EMPTY_BIT] = shift_register_empty;
      end
      `AST_OFS_DIV:
        rd_byte = s.divisor;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    n         = s;
    wr_buf    = 1'b0;
    transmit_enable_rise = 1'b0;
    load      = 1'b0;
    restart   = 1'b0;

    // capture address and data in either order
    if (s_axi_awvalid_in && !s.aw_full)
    begin
      n.aw_full = 1'b1;
      n.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s.w_full)
    begin
      n.w_full = 1'b1;
      n.w_data = s_axi_wdata_in[7:0];
      n.w_be   = s_axi_wstrb_in[0];
    end
    if (s.bvalid && s_axi_bready_in)
      n.bvalid = 1'b0;

    // register write once both halves are held
    if (do_write)
    begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `AST_RESP_OKAY;
      case (s.aw_addr)
        `AST_OFS_FLAGS:
          if (s.w_be)
            n.flags = (s.w_data & `AST_WMASK_FLAGS)
                      | (s.flags & ~`AST_WMASK_FLAGS);
        `AST_OFS_ENABLES:
          if (s.w_be)
            n.enables = s.w_data & `AST_WMASK_ENABLES;
        `AST_OFS_PRIO:
          if (s.w_be)
            n.priorities = s.w_data & `AST_WMASK_PRIO;
        `AST_OFS_RXSTA:
          if (s.w_be)
            n.rx_ctrl = s.w_data & `AST_WMASK_RXSTA;
        `AST_OFS_TXBUF:
          if (s.w_be)
          begin
            n.tx_buf   = s.w_data;
            n.buf_full = 1'b1;
            wr_buf     = 1'b1;
          end
        `AST_OFS_TRANSMIT_STATUS_CONTROL:
          if (s.w_be)
          begin
            n.tx_ctrl = (s.w_data & `AST_WMASK_TRANSMIT_STATUS_CONTROL)
                        | (s.tx_ctrl & ~`AST_WMASK_TRANSMIT_STATUS_CONTROL);
            transmit_enable_rise = s.w_data[`AST_TRANSMIT_ENABLE_BIT]
                        && !s.tx_ctrl[`AST_TRANSMIT_ENABLE_BIT];
          end
        `AST_OFS_DIV:
          if (s.w_be)
            n.divisor = s.w_data;
        default:
          n.bresp = `AST_RESP_SLVERR;
      endcase
    end

    // read answers one cycle after the address is taken
    if (s.rvalid && s_axi_rready_in)
      n.rvalid = 1'b0;
    if (s_axi_arvalid_in && !s.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata  = rd_byte;
      n.rresp  = rd_hit ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
    end

    // shifter; a buffer write in the same cycle defers the load,
    // so the flag clear and the flag set never collide
    if (!active)
    begin
      n.state   = AST_IDLE;
      n.bit_cnt = 4'h0;
      n.tx_line = `AST_LINE_MARK;
    end
    else if (!sleep_in)
    begin
      case (s.state)
        AST_IDLE:
        begin
          n.tx_line = `AST_LINE_MARK;
          if (s.buf_full && !wr_buf)
          begin
            load    = 1'b1;
            restart = 1'b1;
          end
        end
        AST_START:
          if (bit_tick)
          begin
            n.state   = AST_DATA;
            n.bit_cnt = 4'h0;
            n.tx_line = s.transmit_shift_register[0];
            n.transmit_shift_register     = {1'b0, s.transmit_shift_register[8:1]};
          end
        AST_DATA:
          if (bit_tick)
          begin
            if (s.bit_cnt == last_bit)
            begin
              n.state   = AST_STOP;
              n.tx_line = `AST_LINE_MARK;
            end
            else
            begin
              n.bit_cnt = s.bit_cnt + 4'h1;
              n.tx_line = s.transmit_shift_register[0];
              n.transmit_shift_register     = {1'b0, s.transmit_shift_register[8:1]};
            end
          end
        AST_STOP:
          if (bit_tick)
          begin
            if (s.buf_full && !wr_buf)
              load = 1'b1;
            else
              n.state = AST_IDLE;
          end
        default:
        begin
          n.state   = AST_IDLE;
          n.tx_line = `AST_LINE_MARK;
        end
      endcase
    end

    // single-cycle transfer from buffer to shift register
    if (load)
    begin
      // ninth bit carries software parity or address mark
      n.transmit_shift_register      = {s.tx_ctrl[`AST_NINTH_DATA_BIT_BIT], s.tx_buf};
      n.buf_full = 1'b0;
      n.state    = AST_START;
      n.tx_line  = `AST_LINE_SPACE;
    end

    // flag: buffer write clears, set wins over clear
    if (wr_buf)
      n.flags[`AST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] = 1'b0;
    if (load || transmit_enable_rise)
      n.flags[`AST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s            <= '0;
      s.state      <= AST_IDLE;
      s.tx_line    <= `AST_LINE_MARK;
      s.bresp      <= `AST_RESP_OKAY;
      s.rresp      <= `AST_RESP_OKAY;
      s.flags      <= `AST_RST_FLAGS;
      s.enables    <= `AST_RST_ENABLES;
      s.priorities <= `AST_RST_PRIO;
      s.rx_ctrl    <= `AST_RST_RXSTA;
      s.tx_buf     <= `AST_RST_TXBUF;
      s.tx_ctrl    <= `AST_RST_TRANSMIT_STATUS_CONTROL;
      s.divisor    <= `AST_RST_DIV;
    end
    else
    begin
      s <= n;
    end
  end

endmodule

// ==== ast_defines.svh ====
// register map, field positions, reset values and divider figures
// assumes byte addresses on an 8-bit AXI4-Lite address bus
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// register byte offsets
`define AST_OFS_FLAGS     8'h00
`define AST_OFS_ENABLES   8'h04
`define AST_OFS_PRIO      8'h08
`define AST_OFS_RXSTA     8'h0c
`define AST_OFS_TXBUF     8'h10
`define AST_OFS_TRANSMIT_STATUS_CONTROL     8'h14
`define AST_OFS_DIV       8'h18

// reset values
`define AST_RST_FLAGS     8'h00
`define AST_RST_ENABLES   8'h00
`define AST_RST_PRIO      8'h00
`define AST_RST_RXSTA     8'h00
`define AST_RST_TXBUF     8'h00
`define AST_RST_TRANSMIT_STATUS_CONTROL     8'h02
`define AST_RST_DIV       8'h00

// software-writable bits of each register but the buffer and divisor, which take all eight bits
`define AST_WMASK_FLAGS   8'h6f
`define AST_WMASK_ENABLES 8'h7f
`define AST_WMASK_PRIO    8'h7f
`define AST_WMASK_RXSTA   8'hf7
`define AST_WMASK_TRANSMIT_STATUS_CONTROL   8'hfd

// field positions
`define AST_TRANSMIT_BUFFER_EMPTY_FLAG_BIT      4
`define AST_TRANSMIT_INTERRUPT_ENABLE_BIT      4
`define AST_SERIAL_PORT_ENABLE_BIT      7
`define AST_TX9_BIT       6
`define AST_TRANSMIT_ENABLE_BIT      5
`define AST_SYNC_BIT      4
`define AST_HIGH_SPEED_BAUD_SELECT_BIT      2
`define AST_SHIFT_REGISTER_EMPTY_BIT      1
`define AST_NINTH_DATA_BIT_BIT      0

// serial framing
`define AST_LAST_BIT_8    4'h7
`define AST_LAST_BIT_9    4'h8
`define AST_LINE_MARK     1'b1
`define AST_LINE_SPACE    1'b0

// baud prescaler terminal counts (x16, x64)
`define AST_PRE_LAST_HI   6'h0f
`define AST_PRE_LAST_LO   6'h3f

// AXI responses
`define AST_RESP_OKAY     2'h0
`define AST_RESP_SLVERR   2'h2

`endif

// ==== ast_pkg.sv ====
// types shared by the serial transmitter and its baud generator
// assumes ast_defines.svh holds the register and framing constants; state codes are here
package ast_pkg;

  typedef enum logic [3:0]
  {
    AST_IDLE  = 4'h1,
    AST_START = 4'h2,
    AST_DATA  = 4'h4,
    AST_STOP  = 4'h8
  } ast_tx_state_t;

  typedef struct packed
  {
    logic [7:0] div_cnt;
    logic [5:0] pre_cnt;
  } ast_baud_t;

  typedef struct packed
  {
    logic          aw_full;
    logic [7:0]    aw_addr;
    logic          w_full;
    logic [7:0]    w_data;
    logic          w_be;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [7:0]    rdata;
    logic [1:0]    rresp;
    logic [7:0]    flags;
    logic [7:0]    enables;
    logic [7:0]    priorities;
    logic [7:0]    rx_ctrl;
    logic [7:0]    tx_buf;
    logic [7:0]    tx_ctrl;
    logic [7:0]    divisor;
    logic          buf_full;
    ast_tx_state_t state;
    logic [8:0]    transmit_shift_register;
    logic [3:0]    bit_cnt;
    logic          tx_line;
  } ast_regs_t;

endpackage

// ==== ast_baud_gen.sv ====
// divisor counter plus x16/x64 prescaler, one bit tick per bit time
// assumes one clock; enable clears, hold freezes, restart realigns
`timescale 1ns/1ps
`include "ast_defines.svh"
module ast_baud_gen
  import ast_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  // control
  input  wire logic             enable_in,
  input  wire logic             hold_in,
  input  wire logic             restart_in,
  input  wire logic             high_speed_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  // tick
  output logic                  bit_tick_out
);

  ast_baud_t s;
  ast_baud_t n;
  logic [5:0] pre_last;

  // select high gives the x16 prescale, the faster rate
  assign pre_last = high_speed_in ? `AST_PRE_LAST_HI : `AST_PRE_LAST_LO;
  // period is (divisor + 1) * 16 or * 64 clocks
  assign bit_tick_out = enable_in && !hold_in && !restart_in
                        && (s.div_cnt == 8'h00) && (s.pre_cnt == pre_last);

  always_comb
  begin
    n = s;
    if (!enable_in || restart_in)
    begin
      n.div_cnt = divisor_in;
      n.pre_cnt = 6'h00;
    end
    else if (!hold_in)
    begin
      if (s.div_cnt == 8'h00)
      begin
        n.div_cnt = divisor_in;
        n.pre_cnt = (s.pre_cnt == pre_last) ? 6'h00 : s.pre_cnt + 6'h01;
      end
      else
      begin
        n.div_cnt = s.div_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      s <= '0;
    else
      s <= n;
  end

endmodule

// ==== ast_transmitter_asserts.sv ====
// port checker for the serial transmitter
// assumes a bind onto ast_transmitter; one clock domain
`timescale 1ns/1ps
module ast_tx_checker (
  // clock, reset, power
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        sleep_in,
  // register bus
  input  wire logic        s_axi_awvalid_in,
  input  wire logic        s_axi_awready_out,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic        s_axi_wready_out,
  input  wire logic        s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [1:0]  s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  input  wire logic        s_axi_arready_out,
  input  wire logic        s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [31:0] s_axi_rdata_out,
  // serial line
  input  wire logic        tx_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_sleep_freeze: assert property (sleep_in |=> $stable(tx_out))
    else $error("line moved during sleep");
  // shortest bit is sixteen clocks, so eight is a safe floor
  a_start_hold: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("start bit too short");
  a_bit_hold: assert property ($rose(tx_out) |-> tx_out [*8])
    else $error("high bit too short");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before taken");
  a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out && !s_axi_bvalid_out |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
endmodule

// ==== ast_rx_model.sv ====
// behavioural remote receiver, samples each bit at its middle
// assumes the bench gives bit time in clocks and the frame width
`timescale 1ns/1ps
module ast_rx_model (
  // clock, line and hold
  input  wire logic        clock_in,
  input  wire logic        line_in,
  input  wire logic        hold_in,
  // frame setup
  input  wire logic [15:0] bit_clks_in,
  input  wire logic        nine_in,
  // received frame: stop, ninth, byte
  output logic             got_out,
  output logic [9:0]       frame_out
);
  logic [9:0] sh;

  // a frozen transmitter freezes the bit timer too
  task automatic wait_clks(input int c);
    int k;
    k = 0;
    while (k < c)
    begin
      @(posedge clock_in);
      if (!hold_in) k++;
    end
  endtask

  initial
  begin
    got_out = 1'b0;
    frame_out = 10'h0;
    forever
    begin
      @(negedge line_in);
      wait_clks(bit_clks_in / 2);
      sh = 10'h0;
      for (int i = 0; i < (nine_in ? 9 : 8); i++)
      begin
        wait_clks(bit_clks_in);
        sh[i] = line_in;
      end
      wait_clks(bit_clks_in);
      sh[9] = line_in;
      frame_out <= sh;
      got_out <= 1'b1;
      @(posedge clock_in);
      got_out <= 1'b0;
    end
  end
endmodule

// ==== ast_transmitter_tb_top.sv ====
// bench for the serial transmitter: bus tasks, receiver, result queues
// assumes 40 MHz clock and the byte offsets of ast_defines.svh
`timescale 1ns/1ps
`include "ast_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module ast_transmitter_tb_top;
  logic        clk, rst_b, slp, awv, wv, br, arv, rr, nine;
  logic        awr, wr_, bv, arr, rv, tx, req, got;
  logic [7:0]  awa, ara, b8;
  logic [31:0] wd, rdat, seed;
  logic [3:0]  ws, strb;
  logic [1:0]  bresp, rresp, b;
  logic [9:0]  frm, f;
  logic [15:0] bit_clks;
  logic [33:0] e;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [9:0]  fq[$];
  int          error_cnt, n_tests;

  always #12.5 clk = ~clk;

  ast_transmitter dut_u (.clock_in(clk), .rst_b_in(rst_b), .sleep_in(slp),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .tx_out(tx), .transmit_request_out(req));

  ast_rx_model rx_u (.clock_in(clk), .line_in(tx), .hold_in(slp), .bit_clks_in(bit_clks),
    .nine_in(nine), .got_out(got), .frame_out(frm));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic da, dw;
    da = 0;
    dw = 0;
    bq.push_back(r);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= {24'(rnd()), d}; ws <= strb; br <= 1'(rnd());
    while (!(da && dw))
    begin
      @(posedge clk);
      if (awr) begin da = 1; awv <= 1'b0; end
      if (wr_) begin dw = 1; wv <= 1'b0; end
    end
    forever
    begin
      @(posedge clk);
      if (bv && br) break;
      if (bv) br <= 1'b1;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    rq.push_back({r, 24'h0, v});
    arv <= 1'b1; ara <= a; rr <= 1'(rnd());
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    forever
    begin
      @(posedge clk);
      if (rv && rr) break;
      if (rv) rr <= 1'b1;
    end
  endtask

  task automatic send(input logic ninth);
    b8 = 8'(rnd());
    fq.push_back({1'b1, ninth, b8});
    wr(`AST_OFS_TXBUF, b8, `AST_RESP_OKAY);
  endtask

  always @(posedge clk)
  begin
    if (rv && rr) begin e = rq.pop_front(); `CHK({rresp, rdat}, e) end
    if (bv && br) begin b = bq.pop_front(); `CHK(bresp, b) end
    if (got) begin f = fq.pop_front(); `CHK(frm, f) end
  end

  task tally_and_finish();
    if (rq.size() + bq.size() + fq.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // about eight thousand clocks of traffic expected
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    clk = 0; rst_b = 0; slp = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = 0; ara = 0; wd = 0; ws = 0; seed = 32'he757; bit_clks = 16'h10; nine = 0;
    strb = 4'hf;
    error_cnt = 0; n_tests = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`AST_OFS_FLAGS, `AST_RST_FLAGS, `AST_RESP_OKAY);
    rd(`AST_OFS_ENABLES, `AST_RST_ENABLES, `AST_RESP_OKAY);
    rd(`AST_OFS_PRIO, `AST_RST_PRIO, `AST_RESP_OKAY);
    rd(`AST_OFS_RXSTA, `AST_RST_RXSTA, `AST_RESP_OKAY);
    rd(`AST_OFS_TXBUF, `AST_RST_TXBUF, `AST_RESP_OKAY);
    rd(`AST_OFS_TRANSMIT_STATUS_CONTROL, `AST_RST_TRANSMIT_STATUS_CONTROL, `AST_RESP_OKAY);
    rd(`AST_OFS_DIV, `AST_RST_DIV, `AST_RESP_OKAY);
    rd(8'h1c, 8'h00, `AST_RESP_SLVERR);
    wr(8'h1c, 8'hff, `AST_RESP_SLVERR);
    // low byte strobe off: nothing stored, nothing queued for sending
    strb = 4'he;
    wr(`AST_OFS_TXBUF, 8'h55, `AST_RESP_OKAY);
    strb = 4'hf;
    rd(`AST_OFS_TXBUF, `AST_RST_TXBUF, `AST_RESP_OKAY);
    wr(`AST_OFS_FLAGS, 8'hff, `AST_RESP_OKAY);
    rd(`AST_OFS_FLAGS, `AST_WMASK_FLAGS, `AST_RESP_OKAY);
    wr(`AST_OFS_FLAGS, 8'h00, `AST_RESP_OKAY);
    wr(`AST_OFS_DIV, 8'h00, `AST_RESP_OKAY);
    wr(`AST_OFS_RXSTA, 8'h80, `AST_RESP_OKAY);
    wr(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h24, `AST_RESP_OKAY);
    rd(`AST_OFS_FLAGS, 8'h10, `AST_RESP_OKAY);
    `CHK(req, 1'b0)
    wr(`AST_OFS_ENABLES, 8'h10, `AST_RESP_OKAY);
    `CHK(req, 1'b1)
    wr(`AST_OFS_FLAGS, 8'h00, `AST_RESP_OKAY);
    rd(`AST_OFS_FLAGS, 8'h10, `AST_RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      send(1'b0);
      if (i > 0) rd(`AST_OFS_FLAGS, 8'h00, `AST_RESP_OKAY);
      rd(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h24, `AST_RESP_OKAY);
      while (!req) @(posedge clk);
    end
    while (fq.size() != 0) @(posedge clk);
    repeat (40) @(posedge clk);
    `CHK(tx, 1'b1)
    rd(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h26, `AST_RESP_OKAY);
    wr(`AST_OFS_DIV, 8'h02, `AST_RESP_OKAY);
    bit_clks = 16'd192;
    nine = 1'b1;
    wr(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h61, `AST_RESP_OKAY);
    send(1'b1);
    wr(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h60, `AST_RESP_OKAY);
    send(1'b0);
    while (fq.size() != 0) @(posedge clk);
    send(1'b0);
    repeat (300) @(posedge clk);
    slp <= 1'b1;
    repeat (300) @(posedge clk);
    slp <= 1'b0;
    while (fq.size() != 0) @(posedge clk);
    repeat (200) @(posedge clk);
    wr(`AST_OFS_TRANSMIT_STATUS_CONTROL, 8'h70, `AST_RESP_OKAY);
    wr(`AST_OFS_TXBUF, 8'h00, `AST_RESP_OKAY);
    repeat (300) @(posedge clk);
    `CHK(tx, 1'b1)
    tally_and_finish();
  end
endmodule

bind ast_transmitter ast_tx_checker chk_u (.clock_in(clock_in), .rst_b_in(rst_b_in),
  .sleep_in(sleep_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out), .tx_out(tx_out));
